// ---- hdl/sfor_routing.v ----
// sequence flag output routing to general output ports
`timescale 1ns/1ps
`include "sfor_consts.vh"
module sfor_routing #(
  parameter NPORTS = `SFOR_NPORTS
) (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [`SFOR_MODE_W-1:0] op_mode,
  input wire seq_executing,
  input wire sequence_flag_polarity,
  input wire sel_wr,
  input wire [`SFOR_SEL_W-1:0] sel_wr_data,
  input wire parameter_commit_command,
  input wire [`SFOR_SEL_W-1:0] saved_sel,
  input wire saved_valid,
  input wire [NPORTS-1:0] gp_out_in,
  output wire [NPORTS-1:0] gp_out,
  output wire [NPORTS-1:0] routed_mask,
  output wire [`SFOR_SEL_W-1:0] sel_effective,
  output wire [`SFOR_SEL_W-1:0] sel_pending,
  output wire sel_avail,
  output wire sequence_flag_state_query,
  output wire commit_req,
  output wire [`SFOR_SEL_W-1:0] commit_data
);

  // selection registers
  reg [`SFOR_SEL_W-1:0] eff_ff;
  reg [`SFOR_SEL_W-1:0] nxt_eff;
  reg [`SFOR_SEL_W-1:0] pend_ff;
  reg [`SFOR_SEL_W-1:0] nxt_pend;
  reg load_done_ff;
  reg nxt_load_done;

  // commit request towards the store
  reg commit_req_ff;
  reg nxt_commit_req;
  reg [`SFOR_SEL_W-1:0] commit_data_ff;
  reg [`SFOR_SEL_W-1:0] nxt_commit_data;

  // port outputs
  reg [NPORTS-1:0] gp_out_ff;
  wire [NPORTS-1:0] nxt_gp_out;
  reg [NPORTS-1:0] routed_mask_ff;
  wire [NPORTS-1:0] nxt_routed_mask;

  // readback registers
  reg [`SFOR_SEL_W-1:0] sel_effective_ff;
  reg [`SFOR_SEL_W-1:0] nxt_sel_effective;
  reg [`SFOR_SEL_W-1:0] sel_pending_ff;
  reg [`SFOR_SEL_W-1:0] nxt_sel_pending;
  reg sel_avail_ff;
  reg nxt_sel_avail;
  reg query_ff;
  reg nxt_query;

  // decode
  wire prog_mode;
  wire flag_level;
  wire saved_ok;
  wire wr_ok;
  wire [NPORTS-1:0] hit;

  // programmed-motion mode only
  assign prog_mode = (op_mode == `SFOR_MODE_PROG);

  // polarity applied to raw flag
  assign flag_level = seq_executing ^ ~sequence_flag_polarity;

  // stored value usable only when valid and in range
  assign saved_ok = saved_valid &&
    (saved_sel <= `SFOR_SEL_MAX);

  // writes only in mode 0 and in range
  assign wr_ok = sel_wr && prog_mode &&
    (sel_wr_data <= `SFOR_SEL_MAX);

  // selection next state; effective moves only after reset
  always @* begin
    nxt_load_done = load_done_ff;
    nxt_eff = eff_ff;
    nxt_pend = pend_ff;
    if (!load_done_ff) begin
      // first enabled edge after reset takes saved value if usable, else the reset value
      nxt_load_done = 1'b1;
      if (saved_ok) begin
        nxt_eff = saved_sel;
        nxt_pend = saved_sel;
      end else begin
        nxt_eff = `SFOR_SEL_RESET;
        nxt_pend = `SFOR_SEL_RESET;
      end
    end else if (wr_ok) begin
      // pending only, last write wins
      nxt_pend = sel_wr_data;
    end
  end

  // commit pulse carries the pending value
  always @* begin
    nxt_commit_req = 1'b0;
    nxt_commit_data = commit_data_ff;
    if (load_done_ff && parameter_commit_command) begin
      nxt_commit_req = 1'b1;
      nxt_commit_data = pend_ff;
    end
  end

  // per-port routing
  genvar i;
  generate
    for (i = 0; i < NPORTS; i = i + 1) begin : g_port
      localparam [`SFOR_SEL_W-1:0] PORT_CODE = i + 1;
      // port carries the flag only when named
      assign hit[i] = prog_mode && load_done_ff &&
        (eff_ff == PORT_CODE);
      assign nxt_routed_mask[i] = hit[i];
      // active while executing, inactive otherwise
      assign nxt_gp_out[i] = hit[i] ? flag_level :
        gp_out_in[i];
    end
  endgenerate

  // readback, hidden in pulse modes
  always @* begin
    nxt_sel_avail = prog_mode;
    nxt_query = prog_mode & seq_executing;
    if (prog_mode) begin
      nxt_sel_effective = eff_ff;
      nxt_sel_pending = pend_ff;
    end else begin
      nxt_sel_effective = `SFOR_SEL_NONE;
      nxt_sel_pending = `SFOR_SEL_NONE;
    end
  end

  // selection state, frozen while clk_en is low
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eff_ff <= `SFOR_SEL_RESET;
      pend_ff <= `SFOR_SEL_RESET;
      load_done_ff <= 1'b0;
    end else if (clk_en) begin
      eff_ff <= nxt_eff;
      pend_ff <= nxt_pend;
      load_done_ff <= nxt_load_done;
    end
  end

  // commit registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      commit_req_ff <= 1'b0;
      commit_data_ff <= `SFOR_SEL_RESET;
    end else if (clk_en) begin
      commit_req_ff <= nxt_commit_req;
      commit_data_ff <= nxt_commit_data;
    end
  end

  // port output registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_out_ff <= {NPORTS{1'b0}};
      routed_mask_ff <= {NPORTS{1'b0}};
    end else if (clk_en) begin
      gp_out_ff <= nxt_gp_out;
      routed_mask_ff <= nxt_routed_mask;
    end
  end

  // readback registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_effective_ff <= `SFOR_SEL_RESET;
      sel_pending_ff <= `SFOR_SEL_RESET;
      sel_avail_ff <= 1'b0;
      query_ff <= 1'b0;
    end else if (clk_en) begin
      sel_effective_ff <= nxt_sel_effective;
      sel_pending_ff <= nxt_sel_pending;
      sel_avail_ff <= nxt_sel_avail;
      query_ff <= nxt_query;
    end
  end

  // outputs straight from flip-flops
  assign gp_out = gp_out_ff;
  assign routed_mask = routed_mask_ff;
  assign sel_effective = sel_effective_ff;
  assign sel_pending = sel_pending_ff;
  assign sel_avail = sel_avail_ff;
  assign sequence_flag_state_query = query_ff;
  assign commit_req = commit_req_ff;
  assign commit_data = commit_data_ff;

endmodule // sfor_routing

// ---- pkg/sfor_consts.vh ----
// constants for the sequence flag output routing block
`ifndef SFOR_CONSTS_VH
`define SFOR_CONSTS_VH
`define SFOR_SEL_W 3
`define SFOR_SEL_NONE 3'h0
`define SFOR_SEL_MAX 3'h4
`define SFOR_SEL_RESET 3'h0
`define SFOR_MODE_W 2
`define SFOR_MODE_PROG 2'h0
`define SFOR_NPORTS 4
`endif

// ---- test/sfor_nvm.sv ----
// nonvolatile store model
`timescale 1ns/1ps
module sfor_nvm (input wire core_clk, commit_req, input wire [2:0]
  commit_data, output reg [2:0] saved_sel = 0, output reg saved_valid = 0);
  always @(posedge core_clk) if (commit_req) begin
    {saved_valid, saved_sel} <= {1'b1, commit_data};
  end
endmodule // sfor_nvm

// ---- test/sfor_chk.sv ----
// routing checker
`timescale 1ns/1ps
module sfor_chk (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [1:0] op_mode,
  input wire seq_executing,
  input wire sequence_flag_polarity,
  input wire parameter_commit_command,
  input wire [3:0] gp_out_in,
  input wire [3:0] gp_out,
  input wire [3:0] routed_mask,
  input wire [2:0] sel_effective,
  input wire [2:0] sel_pending,
  input wire sel_avail,
  input wire sequence_flag_state_query,
  input wire commit_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_step; clk_en; endsequence
  sequence s_pulse_mode; clk_en && op_mode != 2'h0; endsequence
  sequence s_no_cmd; clk_en && !parameter_commit_command; endsequence
  property p_map; sel_avail && $past(sel_avail) |-> routed_mask ==
    (sel_effective ? 4'h1 << (sel_effective - 3'h1) : 4'h0); endproperty
  a_map: assert property (p_map) else $error("mask");
  property p_hide; s_pulse_mode |=> !sel_avail && !routed_mask &&
    !sel_effective && !sel_pending && !sequence_flag_state_query;
  endproperty
  a_hide: assert property (p_hide) else $error("hide");
  property p_commit; s_no_cmd |=> !commit_req; endproperty
  a_commit: assert property (p_commit) else $error("commit");
  property p_query; s_step |=> sequence_flag_state_query ==
    $past(seq_executing && op_mode == 2'h0); endproperty
  a_query: assert property (p_query) else $error("query");
  property p_level; s_step |=> (gp_out & routed_mask) ==
    (routed_mask & {4{$past(seq_executing ^ ~sequence_flag_polarity)}});
  endproperty
  a_level: assert property (p_level) else $error("level");
  property p_pass; s_step |=> (gp_out & ~routed_mask) ==
    ($past(gp_out_in) & ~routed_mask); endproperty
  a_pass: assert property (p_pass) else $error("pass");
endmodule // sfor_chk
bind sfor_routing sfor_chk i_chk (.*);

// ---- test/tb_top.sv ----
// routing testbench
`timescale 1ns/1ps
module tb_top;
  reg core_clk=0, rst_n=0, clk_en=1, seq_executing=0, sel_wr=0;
  reg sequence_flag_polarity=1, parameter_commit_command=0;
  reg [1:0] op_mode=0;
  reg [2:0] sel_wr_data=0;
  reg [3:0] gp_out_in=5;
  wire [3:0] gp_out, routed_mask;
  wire [2:0] sel_effective, sel_pending, saved_sel, commit_data;
  wire sel_avail, sequence_flag_state_query, saved_valid, commit_req;
  integer errors=0, checks_done=0, cyc=0;
  sfor_routing i_dut (.*);
  sfor_nvm i_nvm (.*);
  always #25 core_clk = ~core_clk;
  task chk(input string n, input [3:0] s, e); checks_done++;
    if (s !== e) begin errors++; $display("FAIL %s %h %h", n, e, s); end
  endtask
  task go(input w, c, input [2:0] d); @(negedge core_clk)
    {sel_wr, parameter_commit_command, sel_wr_data} = {w, c, d};
    @(negedge core_clk) {sel_wr, parameter_commit_command} = 0; endtask
  task rs; @(negedge core_clk) rst_n = 0; #1000 rst_n = 1; #150; endtask
  task t(input s, p, input [3:0] e); seq_executing = s;
    sequence_flag_polarity = p; #100 chk("gp", gp_out, e); endtask
  task complete_run; $display("errors %0d checks %0d", errors, checks_done);
    if (!errors && checks_done) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish; endtask
  always @(posedge core_clk) if (++cyc > 400) begin errors++; complete_run; end
  initial begin rs; chk("ef", sel_effective, 0);
    go(1, 0, 2); go(1, 0, 5); @(negedge core_clk);
    chk("pd", sel_pending, 2);
    op_mode = 1; go(1, 0, 3); op_mode = 0;
    @(negedge core_clk); chk("pd", sel_pending, 2);
    go(0, 1, 0); chk("cr", commit_req, 1);
    chk("cd", commit_data, 2);
    rs; chk("ef", sel_effective, 2);
    chk("mk", routed_mask, 2);
    t(1, 1, 7);
    chk("q", sequence_flag_state_query, 1);
    t(0, 1, 5);
    t(0, 0, 7);
    clk_en = 0; t(1, 0, 7); clk_en = 1;
    op_mode = 1; t(1, 1, 5);
    chk("av", sel_avail, 0);
    chk("q", sequence_flag_state_query, 0);
    chk("ef", sel_effective, 0);
    complete_run; end
endmodule // tb_top
